// [fepc_pkg.sv]
package fepc_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned WINDOW_US       = 40;  // idle search window
  localparam int unsigned WINDOW_CYCLES   = (WINDOW_US * (CLK_HZ / 1000000)); // rounded down
  localparam int unsigned WDOG_W          = 16;

  // code groups
  localparam logic [4:0] CG_IDLE  = 5'h1f;
  localparam logic [4:0] CG_J     = 5'h18;
  localparam logic [4:0] CG_K     = 5'h11;
  localparam logic [4:0] CG_T     = 5'h0d;
  localparam logic [4:0] CG_R     = 5'h07;
  localparam logic [4:0] CG_BAD0  = 5'h08; // 01000
  localparam logic [4:0] CG_BAD1  = 5'h0c; // 01100
  localparam logic [4:0] CG_BAD2  = 5'h10; // 10000

  // scrambler sequence, x^11 + x^9 + 1
  localparam int unsigned LFSR_W     = 11;
  localparam int unsigned LFSR_TAP_A = 10;
  localparam int unsigned LFSR_TAP_B = 8;
  localparam logic [10:0] LFSR_SEED  = 11'h7ff;

  // bits of idle needed to lock the descrambler key
  localparam logic [5:0]  LOCK_BITS  = 6'h1e;
  // consecutive idle groups that close a frame
  localparam logic [1:0]  IDLE_END   = 2'h2;

  // mlt-3 line levels
  localparam logic [1:0]  MLT_ZERO   = 2'h0;
  localparam logic [1:0]  MLT_POS    = 2'h1;
  localparam logic [1:0]  MLT_NEG    = 2'h3;
  // 6-bit sample thresholds (two's complement)
  localparam logic signed [5:0] SAMPLE_HI = 6'sh10;
  localparam logic signed [5:0] SAMPLE_LO = -6'sh10;

  // valid 5-bit code group? undefined ones return 0
  function automatic logic fepc_valid_cg(input logic [4:0] cg);
    fepc_valid_cg = !(cg inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19});
  endfunction

  // next scrambler state
  function automatic logic [10:0] fepc_lfsr_step(input logic [10:0] s);
    fepc_lfsr_step = {s[9:0], s[LFSR_TAP_A] ^ s[LFSR_TAP_B]};
  endfunction

endpackage

// [fepc_sym_if.sv]
`timescale 1ns/1ps
`default_nettype none
// scrambler key driven by the transmit core, not read by the receive core
interface fepc_sym_if;
  logic [10:0] key;
  logic        bit_en;
  modport src (output key, output bit_en);
  modport dst (input key, input bit_en);
endinterface
`default_nettype wire

// [fepc_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// transmit: scramble, serialise, nrzi, mlt-3
module fepc_tx (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] tx_group,
  output logic            tx_take,
  output logic [1:0]      tx_level,
  fepc_sym_if.src         sym
);

  logic [10:0] lfsr;
  logic [4:0]  shreg;
  logic [2:0]  bitcnt;
  logic        nrzi;
  logic [1:0]  last_nz;
  logic [4:0]  safe_group;
  logic        scr_bit;
  logic        load;
  logic        next_nrzi;
  logic        step;

  ////////////////////////////////////////////////////////////////
  // undefined groups replaced by idle
  assign safe_group = fepc_pkg::fepc_valid_cg(tx_group) ? tx_group : fepc_pkg::CG_IDLE;
  assign load       = (bitcnt == 3'h4);
  assign scr_bit    = shreg[4] ^ lfsr[fepc_pkg::LFSR_TAP_A] ^ lfsr[fepc_pkg::LFSR_TAP_B];
  assign next_nrzi  = nrzi ^ scr_bit;
  assign step       = next_nrzi ^ nrzi; // nrzi transition
  assign sym.key    = lfsr;
  assign sym.bit_en = 1'b1;

  // one bit per cycle out of the 5-bit group
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lfsr    <= fepc_pkg::LFSR_SEED;
      shreg   <= fepc_pkg::CG_IDLE;
      bitcnt  <= 3'h0;
      tx_take <= 1'b0;
    end else begin
      lfsr    <= fepc_pkg::fepc_lfsr_step(lfsr);
      bitcnt  <= load ? 3'h0 : bitcnt + 3'h1;
      shreg   <= load ? safe_group : {shreg[3:0], 1'b0};
      tx_take <= (bitcnt == 3'h3);
    end
  end

  // nrzi then mlt-3: a one steps the level, zero holds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nrzi     <= 1'b0;
      tx_level <= fepc_pkg::MLT_ZERO;
      last_nz  <= fepc_pkg::MLT_NEG;
    end else begin
      nrzi <= next_nrzi;
      if (step) begin
        if (tx_level == fepc_pkg::MLT_ZERO) begin
          tx_level <= (last_nz == fepc_pkg::MLT_NEG) ? fepc_pkg::MLT_POS : fepc_pkg::MLT_NEG;
        end else begin
          last_nz  <= tx_level;
          tx_level <= fepc_pkg::MLT_ZERO;
        end
      end
    end
  end

endmodule // fepc_tx
`default_nettype wire

// [fepc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fepc_top #(
  parameter int unsigned WINDOW_CYC = fepc_pkg::WINDOW_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] tx_group,
  output logic            tx_take,
  output logic [1:0]      tx_level,
  input  wire logic [5:0] rx_sample,
  input  wire logic       descr_bypass,
  output logic [4:0]      rx_group,
  output logic            rx_group_valid,
  output logic            rx_dv,
  output logic            rx_err,
  output logic            rx_locked
);

  fepc_sym_if sym ();

  fepc_tx u_tx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tx_group (tx_group),
    .tx_take  (tx_take),
    .tx_level (tx_level),
    .sym      (sym.src)
  );

  typedef enum logic [1:0] {FEPC_HUNT, FEPC_LOCKED} fepc_lock_t;

  // watchdog counter width
  localparam int unsigned WDOG_BITS = fepc_pkg::WDOG_W;

  // receive state
  fepc_lock_t           lock_st;
  logic [1:0]           prev_lvl;
  logic [10:0]          key;
  logic [5:0]           idle_run;
  logic [9:0]           win;
  logic [2:0]           bitcnt;
  logic [WDOG_BITS-1:0] wdog;
  logic [1:0]           idles;
  logic [4:0]           prev_grp;
  logic                 aligned;

  ////////////////////////////////////////////////////////////////
  // slicer and mlt-3 to nrzi decode
  logic [1:0] cur_lvl;
  logic       nrzi_bit;
  assign cur_lvl  = ($signed(rx_sample) > fepc_pkg::SAMPLE_HI) ? fepc_pkg::MLT_POS :
                    ($signed(rx_sample) < fepc_pkg::SAMPLE_LO) ? fepc_pkg::MLT_NEG :
                    fepc_pkg::MLT_ZERO;
  assign nrzi_bit = (cur_lvl != prev_lvl);

  ////////////////////////////////////////////////////////////////
  // descrambling and group framing
  logic       key_bit;
  logic       plain_bit;
  logic [9:0] next_win;
  logic [4:0] next_grp;
  logic       grp_done;
  logic       is_idle;
  logic       wdog_exp;
  logic       run_ok;
  assign key_bit   = key[fepc_pkg::LFSR_TAP_A] ^ key[fepc_pkg::LFSR_TAP_B];
  assign plain_bit = descr_bypass ? nrzi_bit : (nrzi_bit ^ key_bit);
  assign next_win  = {win[8:0], plain_bit};
  assign next_grp  = next_win[4:0];
  assign grp_done  = aligned ? (bitcnt == 3'h4) : 1'b0;
  assign is_idle   = (next_grp == fepc_pkg::CG_IDLE);
  assign wdog_exp  = (wdog >= WDOG_BITS'(WINDOW_CYC - 1));
  // receive runs only while the key holds and the window is open
  assign run_ok    = (lock_st == FEPC_LOCKED) && !wdog_exp;

  ////////////////////////////////////////////////////////////////
  // frame delimiters, errors and idle search
  logic       jk_seen;
  logic       tr_seen;
  logic       two_idles;
  logic       bad_grp;
  logic       idle_seen;
  logic [1:0] next_idles;
  // j/k only opens a frame when none is open
  assign jk_seen    = !rx_dv && (next_win == {fepc_pkg::CG_J, fepc_pkg::CG_K});
  assign tr_seen    = (prev_grp == fepc_pkg::CG_T) && (next_grp == fepc_pkg::CG_R);
  assign two_idles  = is_idle && (idles == fepc_pkg::IDLE_END - 2'h1);
  assign bad_grp    = !fepc_pkg::fepc_valid_cg(next_grp);
  // group edge unknown before the first j/k, so five ones in a row count as idle
  assign idle_seen  = aligned ? (is_idle && grp_done) : is_idle;
  // saturating count of idle groups in a row
  assign next_idles = !is_idle ? 2'h0 :
                      (idles == fepc_pkg::IDLE_END) ? idles : idles + 2'h1;

  ////////////////////////////////////////////////////////////////
  // key hunt
  logic        hunt;
  logic        lock_now;
  logic [10:0] next_key;
  logic [5:0]  next_idle_run;
  assign hunt          = (lock_st == FEPC_HUNT);
  // idle is all ones, so the inverted line bit is the key stream
  assign next_key      = hunt ? {key[9:0], ~nrzi_bit} : fepc_pkg::fepc_lfsr_step(key);
  assign next_idle_run = (plain_bit || descr_bypass) ? idle_run + 6'h1 : 6'h0;
  assign lock_now      = hunt && (idle_run >= fepc_pkg::LOCK_BITS);

  // front end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_lvl <= fepc_pkg::MLT_ZERO;
    end else begin
      prev_lvl <= cur_lvl;
    end
  end

  // key lock: load from line on idle, then free-run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_st  <= FEPC_HUNT;
      key      <= fepc_pkg::LFSR_SEED;
      idle_run <= 6'h0;
    end else begin
      key <= next_key;
      case (lock_st)
        FEPC_HUNT: begin
          idle_run <= next_idle_run;
          if (lock_now) begin
            lock_st <= FEPC_LOCKED;
          end
        end
        FEPC_LOCKED: begin
          if (wdog_exp) begin
            lock_st  <= FEPC_HUNT;
            idle_run <= 6'h0;
          end
        end
        default: begin
          lock_st  <= FEPC_HUNT;
          idle_run <= 6'h0;
        end
      endcase
    end
  end

  // serial to parallel with alignment on j/k
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      win            <= 10'h0;
      bitcnt         <= 3'h0;
      aligned        <= 1'b0;
      rx_group       <= 5'h0;
      rx_group_valid <= 1'b0;
    end else begin
      win            <= next_win;
      rx_group_valid <= 1'b0;
      if (!run_ok) begin
        aligned <= 1'b0;
      end else if (jk_seen) begin
        aligned        <= 1'b1;
        bitcnt         <= 3'h0;
        rx_group       <= next_grp;
        rx_group_valid <= 1'b1;
      end else if (aligned) begin
        bitcnt <= grp_done ? 3'h0 : bitcnt + 3'h1;
        if (grp_done) begin
          rx_group       <= next_grp;
          rx_group_valid <= 1'b1;
        end
      end
    end
  end

  // data valid and error flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_dv     <= 1'b0;
      rx_err    <= 1'b0;
      rx_locked <= 1'b0;
      idles     <= 2'h0;
      prev_grp  <= 5'h0;
    end else begin
      rx_locked <= (lock_st == FEPC_LOCKED);
      rx_err    <= 1'b0;
      if (!run_ok) begin
        rx_dv <= 1'b0;
        idles <= 2'h0;
      end else if (jk_seen) begin
        rx_dv <= 1'b1;
        idles <= 2'h0;
      end else if (rx_dv && grp_done) begin
        prev_grp <= next_grp;
        idles    <= next_idles;
        if (tr_seen || two_idles) begin
          rx_dv <= 1'b0;
        end else if (bad_grp) begin
          rx_err <= 1'b1;
        end
      end
    end
  end

  // idle watchdog, cleared by every idle seen
  always_ff @(posedge clk) begin
    if (sys_rst || !run_ok) begin
      wdog <= '0;
    end else begin
      wdog <= idle_seen ? '0 : wdog + WDOG_BITS'(1);
    end
  end

endmodule // fepc_top
`default_nettype wire

// [fepc_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module fepc_top_asserts #(
  parameter int unsigned WINDOW_CYC = 800
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       tx_take,
  input wire logic [1:0] tx_level,
  input wire logic       descr_bypass,
  input wire logic       rx_group_valid,
  input wire logic       rx_dv,
  input wire logic       rx_err,
  input wire logic       rx_locked
);
  logic [15:0] dv_cnt; // cycles of unbroken valid data
  // count how long rx_dv stays high
  always_ff @(posedge clk) begin
    if (sys_rst || !rx_dv) dv_cnt <= 16'h0;
    else dv_cnt <= dv_cnt + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_TAKE: assert property (tx_take |=> !tx_take [*4] ##1 tx_take)
    else $error("tx take spacing");
  AST_LEVEL: assert property (tx_level != 2'h2)
    else $error("illegal line level");
  AST_MLT: assert property ($changed(tx_level) && $past(tx_level) != fepc_pkg::MLT_ZERO
    |-> tx_level == fepc_pkg::MLT_ZERO) else $error("mlt-3 skipped zero");
  AST_ERR_DV: assert property (rx_err |-> rx_dv)
    else $error("rx_err outside data");
  AST_ERR_ONE: assert property (rx_err |=> !rx_err [*4])
    else $error("rx_err too long");
  AST_GRP: assert property (rx_group_valid |=> !rx_group_valid [*4])
    else $error("group spacing");
  AST_DV_LOCK: assert property ($rose(rx_dv) |-> rx_locked || descr_bypass)
    else $error("data valid while unlocked");
  AST_WDOG: assert property (dv_cnt <= WINDOW_CYC + 16)
    else $error("watchdog did not abort");
  AST_RST: assert property ($fell(sys_rst) |-> !rx_dv && !rx_locked && tx_level == 2'h0)
    else $error("outputs not cleared by reset");
endmodule // fepc_top_asserts
bind fepc_top fepc_top_asserts #(.WINDOW_CYC(WINDOW_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .tx_take(tx_take), .tx_level(tx_level),
  .descr_bypass(descr_bypass), .rx_group_valid(rx_group_valid), .rx_dv(rx_dv),
  .rx_err(rx_err), .rx_locked(rx_locked));
`default_nettype wire

// [fepc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fepc_far_model (
  input  wire logic       clk,
  input  wire logic [1:0] tx_level,
  input  wire logic       raw_en,
  input  wire logic       raw_bit,
  output logic      [5:0] rx_sample
);
  logic [1:0] lvl = 2'h0; // own level in raw mode
  logic       up  = 1'b1; // next swing positive
  logic [1:0] line;
  // loopback stands in for a compliant remote end
  assign line = raw_en ? lvl : tx_level;
  // raw nrzi ones step the level 0,+,0,-
  always_ff @(posedge clk) begin
    if (raw_en && raw_bit) begin
      lvl <= (lvl != 2'h0) ? 2'h0 : (up ? 2'h1 : 2'h3);
      if (lvl == 2'h0) up <= !up;
    end
  end
  // one cycle of cable, levels to 6-bit codes
  always_ff @(posedge clk) begin
    case (line)
      2'h1: rx_sample <= 6'h18;
      2'h3: rx_sample <= 6'h28;
      default: rx_sample <= 6'h00;
    endcase
  end
endmodule // fepc_far_model
`default_nettype wire

// [test_fepc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_fepc_top;
  logic       clk, sys_rst, descr_bypass, raw_en, raw_bit, watch;
  logic       tx_take, rx_group_valid, rx_dv, rx_err, rx_locked;
  logic [4:0] tx_group, rx_group;
  logic [1:0] tx_level;
  logic [5:0] rx_sample;
  logic [4:0] exp_q[$];
  logic [4:0] data_cg [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                               5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  int         mismatches, n_tests, n_err;
  fepc_top #(.WINDOW_CYC(200)) u_dut (.clk(clk), .sys_rst(sys_rst), .tx_group(tx_group),
    .tx_take(tx_take), .tx_level(tx_level), .rx_sample(rx_sample),
    .descr_bypass(descr_bypass), .rx_group(rx_group), .rx_group_valid(rx_group_valid),
    .rx_dv(rx_dv), .rx_err(rx_err), .rx_locked(rx_locked));
  fepc_far_model u_far (.clk(clk), .tx_level(tx_level), .raw_en(raw_en),
    .raw_bit(raw_bit), .rx_sample(rx_sample));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_grp(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t group %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one group, serial raw bits or through the transmitter
  task automatic put(input logic [4:0] g, input bit keep);
    if (raw_en) begin
      for (int b = 4; b >= 0; b--) begin
        @(posedge clk);
        #1 raw_bit = g[b];
      end
    end else begin
      do begin
        @(posedge clk);
        #1;
      end while (tx_take !== 1'b1);
      tx_group = g;
    end
    if (keep) exp_q.push_back(g);
  endtask
  task automatic idles(input int n);
    repeat (n) put(fepc_pkg::CG_IDLE, 1'b0);
  endtask
  task automatic frame(input int n, input logic [4:0] e0, input logic [4:0] e1);
    put(fepc_pkg::CG_J, 1'b0);
    put(fepc_pkg::CG_K, 1'b0);
    repeat (n) put(data_cg[$urandom_range(0, 15)], watch);
    put(e0, 1'b0);
    put(e1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watcher: errors counted, data groups checked in order
  always @(negedge clk) begin
    if (rx_err === 1'b1) n_err++;
    if (watch && rx_group_valid === 1'b1 && rx_dv === 1'b1 && !(rx_group inside
        {fepc_pkg::CG_J, fepc_pkg::CG_K, fepc_pkg::CG_T, fepc_pkg::CG_R,
         fepc_pkg::CG_IDLE, fepc_pkg::CG_BAD0})) begin
      if (exp_q.size() == 0) chk_bit(1'b0, 1'b1, "extra group");
      else chk_grp(rx_group, exp_q.pop_front());
    end
  end
  // hang guard
  initial begin
    #(50 * 6000);
    mismatches++;
    end_sim;
  end
  // main sequence
  initial begin
    {sys_rst, descr_bypass, raw_en, raw_bit, watch} = 5'h11;
    tx_group = fepc_pkg::CG_IDLE;
    mismatches = 0;
    n_tests = 0;
    n_err = 0;
    void'($urandom(74));
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    idles(40);
    chk_bit(rx_locked, 1'b1, "no lock on idle");
    frame(6, fepc_pkg::CG_T, fepc_pkg::CG_R);
    idles(10);
    chk_bit(rx_dv, 1'b0, "dv after end delimiter");
    // undefined group goes out as idle, so two idles end the frame
    frame(3, fepc_pkg::CG_BAD0, fepc_pkg::CG_IDLE);
    idles(10);
    chk_bit(rx_dv, 1'b0, "dv after two idles");
    chk_bit(n_err == 0, 1'b1, "undefined group sent");
    chk_bit(exp_q.size() == 0, 1'b1, "groups lost");
    // endless data trips the watchdog
    watch = 1'b0;
    frame(56, fepc_pkg::CG_IDLE, fepc_pkg::CG_IDLE);
    chk_bit(rx_locked, 1'b0, "no abort");
    idles(40);
    chk_bit(rx_locked, 1'b1, "no relock");
    // bypass with raw groups, one undefined inside the frame
    {watch, descr_bypass, raw_en} = 3'h7;
    idles(12);
    frame(2, fepc_pkg::CG_BAD0, fepc_pkg::CG_T);
    put(fepc_pkg::CG_R, 1'b0);
    idles(10);
    chk_bit(n_err == 1, 1'b1, "rx_err count");
    chk_bit(exp_q.size() == 0, 1'b1, "bypass groups lost");
    end_sim;
  end
endmodule // test_fepc_top
`default_nettype wire
